//--- logic/pam_pkg.sv
// pam_pkg: constants and carriers for the auxiliary mode and coexistence/negotiation registers
// assumes: a 16-bit management register port with a one-bit register select
package pam_pkg;

    // register select values on the management register port
    localparam logic pam_sel_mode = 1'b0;
    localparam logic pam_sel_coexist = 1'b1;

    // extra mode control field positions
    localparam int pam_mode_idle_insert_bit = 1;
    localparam int pam_mode_link_indicator_led_off_bit = 3;
    localparam int pam_mode_act_led_off_bit = 4;

    // coexistence / negotiation status field positions
    localparam int pam_cx_rxer_code_bit = 0;
    localparam int pam_cx_serial_bit = 1;
    localparam int pam_cx_isolate_bit = 3;
    localparam int pam_cx_ability_bit = 4;
    localparam int pam_cx_ack_det_bit = 5;
    localparam int pam_cx_ack_cpl_bit = 6;
    localparam int pam_cx_an_done_bit = 7;
    localparam int pam_cx_restart_bit = 8;
    localparam int pam_cx_result_lsb = 11;

    // reset values of the stored fields
    localparam logic [15:0] pam_reg_reset = 16'h0000;
    localparam logic [4:0] pam_result_none = 5'h00;

    // idle insertion: idles wanted before a start delimiter, and the deepest stretch
    localparam logic [2:0] pam_min_idles = 3'h2;
    localparam logic [1:0] pam_max_delay = 2'h2;

    // writable fields of the extra mode control register
    typedef struct packed {
        logic idle_insert;
        logic link_indicator_led_off;
        logic act_led_off;
    } pam_mode_s;

    // writable fields of the coexistence register
    typedef struct packed {
        logic rxer_code;
        logic serial_10;
        logic isolate;
    } pam_coexist_s;

    // one transmit nibble with its enable
    typedef struct packed {
        logic en;
        logic [3:0] data;
    } pam_tx_s;

    // negotiation arbitration progress
    typedef enum logic [2:0] {
        pam_an_off,
        pam_an_ability,
        pam_an_ack_det,
        pam_an_ack_cpl,
        pam_an_done
    } pam_an_e;

endpackage

//--- logic/pam_aux_regs.sv
// pam_aux_regs: extra mode control and coexistence/negotiation status registers of the phy,
// with the idle-insertion stage on the transmit clock and the negotiation progress flags.
// assumes: negotiation engine events and the enable pin arrive asynchronously; main control
// register enable and restart come from logic on mclk; transmit nibbles arrive on tx_clk.
// Notes on behaviour
// - mode bit 3 turns link_indicator_led off
// - mode bit 4 turns activity leds off
// - coexist bit 0 selects receive-error code mode
// - coexist bit 1 selects 10 Mb serial mode
// - isolate ignores mii inputs, releases outputs
// - isolate also suppresses all link pulses
// - bit 4 reads one in ability detect
// - bit 5 latches leaving ack detected
// - bit 6 set leaving ack complete
// - bit 7 one after negotiation completes
// - bit 8 restarts negotiation, reads zero
// - restart only works while negotiation enabled
// - bits 11 to 15 one-hot common mode
// - enabled needs control bit and pin high
`timescale 1ns/1ns
`default_nettype none

module pam_aux_regs (
    // system clock and reset
    input wire logic mclk,
    input wire logic reset,
    // management register port
    input wire logic reg_write,
    input wire logic reg_sel,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    // main control register fields
    input wire logic ctrl_an_enable,
    input wire logic ctrl_an_restart,
    // negotiation engine events and pin
    input wire logic negotiation_enable_pin,
    input wire logic an_pulses_seen,
    input wire logic an_ack_seen,
    input wire logic an_ack_done,
    input wire logic link_fault,
    input wire logic [4:0] negotiated_common_mode,
    // led sources and pins
    input wire logic link_up,
    input wire logic tx_activity,
    input wire logic rx_activity,
    output logic link_indicator_led,
    output logic transmit_activity_led_n,
    output logic receive_activity_led_n,
    // mode outputs to the phy core
    output logic short_gap_idle_insert_mode,
    output logic receive_error_code_mode,
    output logic serial_10_mode,
    output logic mii_input_ignore,
    output logic mii_output_enable_n,
    output logic link_pulse_enable,
    output logic an_restart_pulse,
    // transmit path on the link clock
    input wire logic tx_clk,
    input wire logic tx_en_in,
    input wire logic [3:0] txd_in,
    output logic tx_en_out,
    output logic [3:0] txd_out
);

    pam_pkg::pam_mode_s mode;
    pam_pkg::pam_coexist_s coexist;
    pam_pkg::pam_an_e an_state;
    logic ack_detected;
    logic ack_complete;
    logic an_complete;
    logic [4:0] result;
    logic restart_req;

    // three-stage synchronisers for the asynchronous event inputs
    localparam int NS = 5;
    logic [NS-1:0] async_in;
    logic [NS-1:0] m_s1;
    logic [NS-1:0] m_s2;
    logic [NS-1:0] m_s3;
    logic [NS-1:0] m_q;
    assign async_in = {negotiation_enable_pin, an_pulses_seen, an_ack_seen, an_ack_done, link_fault};
    genvar gi;
    generate
        for (gi = 0; gi < NS; gi++) begin : g_msync
            // a change counts only once the second and third stages agree
            always_ff @(posedge mclk or posedge reset) begin
                if (reset) begin
                    m_s1[gi] <= 1'b0;
                    m_s2[gi] <= 1'b0;
                    m_s3[gi] <= 1'b0;
                    m_q[gi] <= 1'b0;
                end else begin
                    m_s1[gi] <= async_in[gi];
                    m_s2[gi] <= m_s1[gi];
                    m_s3[gi] <= m_s2[gi];
                    if (m_s2[gi] == m_s3[gi]) begin
                        m_q[gi] <= m_s3[gi];
                    end
                end
            end
        end
    endgenerate
    wire pin_en = m_q[4];
    wire pulses = m_q[3];
    wire ack_seen = m_q[2];
    wire ack_done = m_q[1];
    wire fault = m_q[0];
    // decode of the register port
    wire an_enabled = ctrl_an_enable & pin_en;
    wire wr_mode = reg_write & (reg_sel == pam_pkg::pam_sel_mode);
    wire wr_cx = reg_write & (reg_sel == pam_pkg::pam_sel_coexist);
    wire restart_now = an_enabled & ((wr_cx & reg_wdata[pam_pkg::pam_cx_restart_bit]) | ctrl_an_restart);

    // writable control fields; all other bit positions are not stored
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            mode <= '0;
            coexist <= '0;
        end else begin
            if (wr_mode) begin
                mode.idle_insert <= reg_wdata[pam_pkg::pam_mode_idle_insert_bit];
                mode.link_indicator_led_off <= reg_wdata[pam_pkg::pam_mode_link_indicator_led_off_bit];
                mode.act_led_off <= reg_wdata[pam_pkg::pam_mode_act_led_off_bit];
            end
            if (wr_cx) begin
                coexist.rxer_code <= reg_wdata[pam_pkg::pam_cx_rxer_code_bit];
                coexist.serial_10 <= reg_wdata[pam_pkg::pam_cx_serial_bit];
                coexist.isolate <= reg_wdata[pam_pkg::pam_cx_isolate_bit];
            end
        end
    end

    // arbitration progress; disable or restart win over any partner event
    pam_pkg::pam_an_e next_an_state;
    always_comb begin
        next_an_state = an_state;
        if (!an_enabled) begin
            next_an_state = pam_pkg::pam_an_off;
        end else if (restart_req) begin
            next_an_state = pam_pkg::pam_an_ability;
        end else begin
            case (an_state)
                pam_pkg::pam_an_off: next_an_state = pam_pkg::pam_an_ability;
                pam_pkg::pam_an_ability: begin
                    if (pulses) begin
                        next_an_state = pam_pkg::pam_an_ack_det;
                    end
                end
                pam_pkg::pam_an_ack_det: begin
                    if (fault) begin
                        next_an_state = pam_pkg::pam_an_ability;
                    end else if (ack_seen) begin
                        next_an_state = pam_pkg::pam_an_ack_cpl;
                    end
                end
                pam_pkg::pam_an_ack_cpl: begin
                    if (fault) begin
                        next_an_state = pam_pkg::pam_an_ability;
                    end else if (ack_done) begin
                        next_an_state = pam_pkg::pam_an_done;
                    end
                end
                pam_pkg::pam_an_done: begin
                    if (fault) begin
                        next_an_state = pam_pkg::pam_an_ability;
                    end
                end
                default: next_an_state = pam_pkg::pam_an_off;
            endcase
        end
    end

    wire leave_ack_det = (an_state == pam_pkg::pam_an_ack_det) && (next_an_state == pam_pkg::pam_an_ack_cpl);
    wire leave_ack_cpl = (an_state == pam_pkg::pam_an_ack_cpl) && (next_an_state == pam_pkg::pam_an_done);
    // restart request is held one cycle so it self-clears and never reads back
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            restart_req <= 1'b0;
            an_state <= pam_pkg::pam_an_off;
        end else begin
            restart_req <= restart_now;
            an_state <= next_an_state;
        end
    end

    // progress flags; ack detected survives disable, only restart or reset drop it
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ack_detected <= 1'b0;
            ack_complete <= 1'b0;
            an_complete <= 1'b0;
            result <= pam_pkg::pam_result_none;
        end else begin
            if (leave_ack_det) begin
                ack_detected <= 1'b1;
            end else if (restart_req) begin
                ack_detected <= 1'b0;
            end
            if (leave_ack_cpl) begin
                ack_complete <= 1'b1;
            end else if (restart_req || fault || !an_enabled) begin
                ack_complete <= 1'b0;
            end
            if (leave_ack_cpl) begin
                an_complete <= 1'b1;
                result <= negotiated_common_mode;
            end else if (restart_req || !an_enabled) begin
                an_complete <= 1'b0;
                result <= pam_pkg::pam_result_none;
            end
        end
    end

    // read word assembly; undefined positions stay zero
    logic [15:0] mode_word;
    logic [15:0] cx_word;
    always_comb begin
        mode_word = pam_pkg::pam_reg_reset;
        mode_word[pam_pkg::pam_mode_idle_insert_bit] = mode.idle_insert;
        mode_word[pam_pkg::pam_mode_link_indicator_led_off_bit] = mode.link_indicator_led_off;
        mode_word[pam_pkg::pam_mode_act_led_off_bit] = mode.act_led_off;
        cx_word = pam_pkg::pam_reg_reset;
        cx_word[pam_pkg::pam_cx_rxer_code_bit] = coexist.rxer_code;
        cx_word[pam_pkg::pam_cx_serial_bit] = coexist.serial_10;
        cx_word[pam_pkg::pam_cx_isolate_bit] = coexist.isolate;
        cx_word[pam_pkg::pam_cx_ability_bit] = (an_state == pam_pkg::pam_an_ability);
        cx_word[pam_pkg::pam_cx_ack_det_bit] = ack_detected;
        cx_word[pam_pkg::pam_cx_ack_cpl_bit] = ack_complete;
        cx_word[pam_pkg::pam_cx_an_done_bit] = an_complete;
        cx_word[pam_pkg::pam_cx_result_lsb +: 5] = result;
    end

    // registered outputs toward pins and the phy core
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            reg_rdata <= '0;
            link_indicator_led <= 1'b0;
            transmit_activity_led_n <= 1'b1;
            receive_activity_led_n <= 1'b1;
            short_gap_idle_insert_mode <= 1'b0;
            receive_error_code_mode <= 1'b0;
            serial_10_mode <= 1'b0;
            mii_input_ignore <= 1'b0;
            mii_output_enable_n <= 1'b0;
            link_pulse_enable <= 1'b1;
            an_restart_pulse <= 1'b0;
        end else begin
            reg_rdata <= (reg_sel == pam_pkg::pam_sel_coexist) ? cx_word : mode_word;
            link_indicator_led <= link_up & ~mode.link_indicator_led_off;
            transmit_activity_led_n <= ~(tx_activity & ~mode.act_led_off);
            receive_activity_led_n <= ~(rx_activity & ~mode.act_led_off);
            short_gap_idle_insert_mode <= mode.idle_insert;
            receive_error_code_mode <= coexist.rxer_code;
            serial_10_mode <= coexist.serial_10;
            mii_input_ignore <= coexist.isolate;
            mii_output_enable_n <= coexist.isolate;
            link_pulse_enable <= ~coexist.isolate;
            an_restart_pulse <= restart_req;
        end
    end

    // mode bits crossing into the transmit clock domain
    logic [1:0] t_s1;
    logic [1:0] t_s2;
    logic [1:0] t_s3;
    logic [1:0] t_q;
    wire [1:0] t_src = {coexist.isolate, mode.idle_insert};
    generate
        for (gi = 0; gi < 2; gi++) begin : g_tsync
            always_ff @(posedge tx_clk or posedge reset) begin
                if (reset) begin
                    t_s1[gi] <= 1'b0;
                    t_s2[gi] <= 1'b0;
                    t_s3[gi] <= 1'b0;
                    t_q[gi] <= 1'b0;
                end else begin
                    t_s1[gi] <= t_src[gi];
                    t_s2[gi] <= t_s1[gi];
                    t_s3[gi] <= t_s2[gi];
                    if (t_s2[gi] == t_s3[gi]) begin
                        t_q[gi] <= t_s3[gi];
                    end
                end
            end
        end
    endgenerate
    // idle insertion: a three-tap delay line; the tap grows to hold a start delimiter back
    // and shrinks again over idle input. a run of one-cycle gaps beyond two deep is not stretched.
    pam_pkg::pam_tx_s tap [0:2];
    logic [1:0] delay;
    logic [2:0] idle_run;
    logic [1:0] next_delay;
    pam_pkg::pam_tx_s cur;
    pam_pkg::pam_tx_s shorter;
    assign cur = tap[delay];
    assign shorter = (delay == 2'h0) ? tap[0] : tap[delay - 2'h1];
    wire hold_start = t_q[0] & cur.en & ~tx_en_out & (idle_run < pam_pkg::pam_min_idles)
                      & (delay < pam_pkg::pam_max_delay);
    wire catch_up = (delay != 2'h0) & ~cur.en & ~shorter.en & (idle_run >= pam_pkg::pam_min_idles);
    always_comb begin
        next_delay = delay;
        if (hold_start) begin
            next_delay = delay + 2'h1;
        end else if (catch_up) begin
            next_delay = delay - 2'h1;
        end
    end

    // transmit stage; isolation drops the enable so nothing is sent
    always_ff @(posedge tx_clk or posedge reset) begin
        if (reset) begin
            tap[0] <= '0;
            tap[1] <= '0;
            tap[2] <= '0;
            delay <= 2'h0;
            idle_run <= 3'h0;
            tx_en_out <= 1'b0;
            txd_out <= 4'h0;
        end else begin
            tap[0] <= {tx_en_in, txd_in};
            tap[1] <= tap[0];
            tap[2] <= tap[1];
            delay <= next_delay;
            tx_en_out <= cur.en & ~hold_start & ~t_q[1];
            txd_out <= (hold_start | t_q[1]) ? 4'h0 : cur.data;
            if (cur.en & ~hold_start) begin
                idle_run <= 3'h0;
            end else if (idle_run != 3'h7) begin
                idle_run <= idle_run + 3'h1;
            end
        end
    end

endmodule

`default_nettype wire

//--- verification/pam_aux_monitor.sv
// pam_aux_monitor: port checks for the auxiliary mode and negotiation registers
// assumes: mclk and tx_clk domains share one asynchronous reset
`timescale 1ns/1ns
`default_nettype none

module pam_aux_monitor (
    // clocks and reset
    input wire logic mclk,
    input wire logic tx_clk,
    input wire logic reset,
    // register port
    input wire logic reg_write,
    input wire logic reg_sel,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    // control and mode pins
    input wire logic ctrl_an_enable,
    input wire logic short_gap_idle_insert_mode,
    input wire logic mii_input_ignore,
    input wire logic mii_output_enable_n,
    input wire logic link_pulse_enable,
    input wire logic an_restart_pulse,
    // transmit path
    input wire logic tx_en_in,
    input wire logic tx_en_out
);
    // a mode write, then a cycle that keeps the same select
    sequence s_mode_write;
        reg_write && !reg_sel ##1 !reg_sel;
    endsequence

    a_mode_read_back: assert property (@(posedge mclk) disable iff (reset)
        s_mode_write |=> reg_rdata == ($past(reg_wdata, 2) & 16'h001a)) else $error("mode read back wrong");
    a_cx_fixed_zero: assert property (@(posedge mclk) disable iff (reset)
        $past(reg_sel) |-> reg_rdata[2] == 1'b0 && reg_rdata[10:8] == 3'h0) else $error("fixed bits not zero");
    a_result_one_hot: assert property (@(posedge mclk) disable iff (reset)
        $past(reg_sel) |-> $onehot0(reg_rdata[15:11])) else $error("result not one-hot");
    a_done_has_result: assert property (@(posedge mclk) disable iff (reset)
        $past(reg_sel) && reg_rdata[7] |-> $onehot(reg_rdata[15:11])) else $error("done without result");
    a_ability_no_ack: assert property (@(posedge mclk) disable iff (reset)
        $past(reg_sel) && reg_rdata[4] |-> !reg_rdata[6]) else $error("ack complete in ability");
    a_iso_pair_move: assert property (@(posedge mclk) disable iff (reset)
        mii_output_enable_n == mii_input_ignore) else $error("isolate pins disagree");
    a_iso_no_pulses: assert property (@(posedge mclk) disable iff (reset)
        mii_output_enable_n |-> !link_pulse_enable) else $error("link pulses while isolated");
    a_restart_one_cycle: assert property (@(posedge mclk) disable iff (reset)
        an_restart_pulse |=> !an_restart_pulse) else $error("restart pulse too long");
    a_restart_needs_en: assert property (@(posedge mclk) disable iff (reset)
        an_restart_pulse |-> $past(ctrl_an_enable, 2)) else $error("restart while disabled");
    // isolation releases the transmit path, so its lag is only bounded while attached
    a_tx_follows_in: assert property (@(posedge tx_clk) disable iff (reset || mii_input_ignore)
        $rose(tx_en_in) |-> ##[2:4] tx_en_out) else $error("transmit start lost");
    a_tx_gap_stretch: assert property (@(posedge tx_clk) disable iff (reset)
        $fell(tx_en_out) && short_gap_idle_insert_mode |=> !tx_en_out) else $error("gap not stretched");
endmodule

bind pam_aux_regs pam_aux_monitor mon (.mclk, .tx_clk, .reset, .reg_write, .reg_sel, .reg_wdata, .reg_rdata,
    .ctrl_an_enable, .short_gap_idle_insert_mode, .mii_input_ignore, .mii_output_enable_n,
    .link_pulse_enable, .an_restart_pulse, .tx_en_in, .tx_en_out);

`default_nettype wire

//--- verification/pam_far_end.sv
// pam_far_end: negotiation engine events and the mac transmit stream
// assumes: event levels cross a synchroniser, so each is held 10 mclk periods
`timescale 1ns/1ns
`default_nettype none

module pam_far_end (
    // link clock
    input wire logic tx_clk,
    // negotiation events
    output logic an_pulses_seen,
    output logic an_ack_seen,
    output logic an_ack_done,
    output logic link_fault,
    output logic [4:0] negotiated_common_mode,
    // mac transmit nibbles
    output logic tx_en_in,
    output logic [3:0] txd_in
);
    // quiet start
    initial begin
        {an_pulses_seen, an_ack_seen, an_ack_done, link_fault} = 4'h0;
        negotiated_common_mode = 5'h00;
        tx_en_in = 1'b0;
        txd_in = 4'h5;
    end

    // result stands before done rises, as the capture needs
    task automatic negotiate(input logic [4:0] res);
        negotiated_common_mode = res;
        #200 an_pulses_seen = 1'b1;
        #200 an_ack_seen = 1'b1;
        #200 an_ack_done = 1'b1;
        #200;
    endtask

    // drop event levels so a restart is not walked straight through
    task automatic quiet();
        {an_pulses_seen, an_ack_seen, an_ack_done} = 3'h0;
        #200;
    endtask

    // one link fault pulse
    task automatic fault();
        link_fault = 1'b1;
        #200 link_fault = 1'b0;
        #200;
    endtask

    // two bursts split by a gap; idle data toggles so stale nibbles never look held
    task automatic send(input int first, input int gap, input int second);
        for (int i = 0; i < first + gap + second + 1; i++) begin
            @(posedge tx_clk);
            tx_en_in <= (i < first) || (i >= first + gap && i < first + gap + second);
            txd_in <= ~txd_in;
        end
    endtask
endmodule

`default_nettype wire

//--- verification/tb_phy_aux_mode_autoneg_status.sv
// tb_phy_aux_mode_autoneg_status: register, led, isolation, negotiation and gap tests
// assumes: pam_far_end supplies negotiation events and transmit nibbles
`timescale 1ns/1ns
`default_nettype none

module tb_phy_aux_mode_autoneg_status;
    logic mclk = 1'b0;
    logic tx_clk, reset, reg_write, reg_sel, ctrl_an_enable, ctrl_an_restart, negotiation_enable_pin;
    logic [15:0] reg_wdata, reg_rdata;
    logic an_pulses_seen, an_ack_seen, an_ack_done, link_fault, link_up, tx_activity, rx_activity;
    logic [4:0] negotiated_common_mode;
    logic link_indicator_led, transmit_activity_led_n, receive_activity_led_n, short_gap_idle_insert_mode;
    logic receive_error_code_mode, serial_10_mode, mii_input_ignore, mii_output_enable_n;
    logic link_pulse_enable, an_restart_pulse, tx_en_in, tx_en_out;
    logic [3:0] txd_in, txd_out;
    int fails = 0;
    int tests_run = 0;
    int pulses = 0;
    int cycles = 0;
    int tx_seen = 0;
    int tx_sum_in = 0;
    int tx_sum_out = 0;

    always #10 mclk = ~mclk;
    // link clock, unrelated in phase
    initial begin
        tx_clk = 1'b0;
        #1;
        forever #15 tx_clk = ~tx_clk;
    end

    pam_aux_regs dut (.mclk, .reset, .reg_write, .reg_sel, .reg_wdata, .reg_rdata, .ctrl_an_enable,
        .ctrl_an_restart, .negotiation_enable_pin, .an_pulses_seen, .an_ack_seen, .an_ack_done, .link_fault,
        .negotiated_common_mode, .link_up, .tx_activity, .rx_activity, .link_indicator_led,
        .transmit_activity_led_n, .receive_activity_led_n, .short_gap_idle_insert_mode, .receive_error_code_mode,
        .serial_10_mode, .mii_input_ignore, .mii_output_enable_n, .link_pulse_enable, .an_restart_pulse,
        .tx_clk, .tx_en_in, .txd_in, .tx_en_out, .txd_out);
    pam_far_end far (.tx_clk, .an_pulses_seen, .an_ack_seen, .an_ack_done, .link_fault,
        .negotiated_common_mode, .tx_en_in, .txd_in);

    // restart pulses and hang ceiling on mclk; delivered nibbles are counted on tx_clk below
    always @(posedge mclk) begin
        cycles++;
        if (an_restart_pulse === 1'b1)
            pulses++;
        if (cycles == 20000) begin
            fails++;
            give_verdict();
        end
    end
    // nibbles offered and delivered; data sums show the stretch neither drops nor repeats one
    always @(posedge tx_clk) begin
        if (tx_en_out === 1'b1) begin
            tx_seen++;
            tx_sum_out += txd_out;
        end
        if (tx_en_in === 1'b1)
            tx_sum_in += txd_in;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic sel, input logic [15:0] data);
        @(posedge mclk);
        reg_sel <= sel;
        reg_write <= 1'b1;
        reg_wdata <= data;
        @(posedge mclk);
        reg_write <= 1'b0;
    endtask
    // read data is registered, so the answer lags the select by one edge
    task automatic rd(input logic sel, input logic [15:0] exp);
        @(posedge mclk);
        reg_sel <= sel;
        repeat (2) @(posedge mclk);
        #1 chk(reg_rdata, exp);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // main sequence
    initial begin
        {reset, reg_write, reg_sel, ctrl_an_enable, ctrl_an_restart, negotiation_enable_pin} = 6'h20;
        {link_up, tx_activity, rx_activity} = 3'h0;
        reg_wdata = 16'h0000;
        repeat (3) @(posedge mclk);
        #1 chk(16'({link_indicator_led, transmit_activity_led_n, receive_activity_led_n,
            mii_output_enable_n, link_pulse_enable}), 16'h000d);
        reset <= 1'b0;
        link_up <= 1'b1;
        tx_activity <= 1'b1;
        rx_activity <= 1'b1;
        wr(0, 16'hffff);
        rd(0, 16'h001a);
        chk(16'({link_indicator_led, transmit_activity_led_n, receive_activity_led_n,
            short_gap_idle_insert_mode}), 16'h0007);
        wr(0, 16'h0000);
        rd(0, 16'h0000);
        chk(16'({link_indicator_led, transmit_activity_led_n, receive_activity_led_n,
            short_gap_idle_insert_mode}), 16'h0008);
        wr(1, 16'hffff);
        rd(1, 16'h000b);
        chk(16'({receive_error_code_mode, serial_10_mode, mii_input_ignore, mii_output_enable_n,
            link_pulse_enable}), 16'h001e);
        chk(16'(pulses), 16'h0000);
        wr(1, 16'h0000);
        rd(1, 16'h0000);
        chk(16'({receive_error_code_mode, serial_10_mode, mii_output_enable_n, link_pulse_enable}), 16'h0001);
        wr(0, 16'h0002);
        far.send(3, 1, 3);
        repeat (10) @(posedge mclk);
        chk(16'(tx_seen), 16'h0006);
        chk(16'(tx_sum_out), 16'(tx_sum_in));
        wr(1, 16'h0008);
        repeat (10) @(posedge mclk);
        far.send(2, 4, 2);
        repeat (10) @(posedge mclk);
        chk(16'(tx_seen), 16'h0006);
        wr(1, 16'h0000);
        ctrl_an_enable <= 1'b1;
        negotiation_enable_pin <= 1'b1;
        repeat (10) @(posedge mclk);
        rd(1, 16'h0010);
        for (int i = 0; i < 5; i++) begin
            far.negotiate(5'(1 << i));
            rd(1, 16'h00e0 | 16'(32'h0800 << i));
            far.quiet();
            wr(1, 16'h0100);
            repeat (8) @(posedge mclk);
            rd(1, 16'h0010);
        end
        chk(16'(pulses), 16'h0005);
        far.negotiate(5'h04);
        far.quiet();
        far.fault();
        rd(1, 16'h20b0);
        @(posedge mclk);
        ctrl_an_restart <= 1'b1;
        @(posedge mclk);
        ctrl_an_restart <= 1'b0;
        repeat (8) @(posedge mclk);
        rd(1, 16'h0010);
        far.negotiate(5'h10);
        negotiation_enable_pin <= 1'b0;
        repeat (10) @(posedge mclk);
        rd(1, 16'h0020);
        wr(1, 16'h0100);
        repeat (8) @(posedge mclk);
        chk(16'(pulses), 16'h0006);
        // a mid-run reset must drop the latched acknowledge flag that survived disable
        @(posedge mclk);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        rd(1, 16'h0000);
        give_verdict();
    end
endmodule

`default_nettype wire
